// *** core/awis_top.sv ***
// top: register port, window flag, positive input selector and temperature sensor control
// Notes on behaviour
// - less-than low byte, read/write, resets zero
// - inside mode flags word strictly between limits
// - outside mode flags word below gt or above lt
// - result is 10-bit unsigned, compared unsigned
// - codes map pins, temp sensor, supply, none
// - select field bits 4:0, top zero, reset ones
// - enable bit in reference control gates sensor
// - offset registers hold factory zero-degree reading
// - compare runs after every conversion automatically
// - each limit is a 16-bit byte pair
// - window flag lives in converter control register
// - greater-than limit bytes reset to all ones
module awis_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr, // register address
  input wire logic [7:0] i_sfr_wdata, // write data
  input wire logic i_sfr_wr, // write strobe
  input wire logic i_sfr_rd, // read strobe
  output logic [7:0] o_sfr_rdata, // read data, one cycle after the strobe
  input wire logic [awis_pkg::CONV_BITS-1:0] i_conv_word, // finished conversion word
  input wire logic i_conv_done, // one-cycle pulse per conversion
  input wire logic [awis_pkg::CONV_BITS-1:0] i_trim_offset, // factory offset, loaded once after reset release
  output logic o_window_flag, // window_match_flag
  output logic [7:0] o_port0_sel, // port 0 pin switches
  output logic [7:0] o_port1_sel, // port 1 pin switches
  output logic o_temp_sel, // temperature sensor switch
  output logic o_supply_sel, // supply switch
  output logic o_temp_sensor_en, // temp_sensor_enable
  output logic [7:0] o_conv_ctrl // converter control bits, window flag in bit 3
);
  import awis_pkg::*;

  // limit registers
  logic [7:0] gt_hi_q, gt_lo_q, lt_hi_q, lt_lo_q;
  // selector field
  logic [4:0] sel_q;
  // converter control bits other than the flag
  logic [7:0] ctrl_q;
  // the sticky window flag
  logic flag_q, flag_d;
  // reference control register
  logic [7:0] ref_q;
  // offset calibration registers, left-justified
  logic [7:0] tofs_hi_q;
  logic [1:0] tofs_lo_q;
  // high once the factory offset has been captured
  logic trim_loaded_q;
  // read data register and its next value
  logic [7:0] rdata_q, rdata_d;
  // per-input switch decode
  logic [PORT_PINS-1:0] pin_sel;

  // write strobes
  wire wr_gt_hi = i_sfr_wr && (i_sfr_addr == ADDR_GT_HI);
  wire wr_gt_lo = i_sfr_wr && (i_sfr_addr == ADDR_GT_LO);
  wire wr_lt_hi = i_sfr_wr && (i_sfr_addr == ADDR_LT_HI);
  wire wr_lt_lo = i_sfr_wr && (i_sfr_addr == ADDR_LT_LO);
  wire wr_sel = i_sfr_wr && (i_sfr_addr == ADDR_INPUT_SEL);
  wire wr_ctrl = i_sfr_wr && (i_sfr_addr == ADDR_CONV_CTRL);
  wire wr_ref = i_sfr_wr && (i_sfr_addr == ADDR_REF_CTRL);
  wire wr_tofs_hi = i_sfr_wr && (i_sfr_addr == ADDR_TEMP_OFS_HI);
  wire wr_tofs_lo = i_sfr_wr && (i_sfr_addr == ADDR_TEMP_OFS_LO);

  // comparator link
  awis_win_if win ();
  assign win.gt_word = {gt_hi_q, gt_lo_q};
  assign win.lt_word = {lt_hi_q, lt_lo_q};
  assign win.conv_word = {6'h00, i_conv_word};

  awis_window_cmp u_cmp (
    .win(win)
  );

  // a match on a finished conversion sets the flag
  wire win_hit = i_conv_done && win.match;
  // a write of zero to the flag bit clears it
  wire flag_clr = wr_ctrl && !i_sfr_wdata[WIN_FLAG_BIT];

  // flag next value: a hit wins over a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (win_hit) begin
      flag_d = 1'b1;
    end else if (flag_clr) begin
      flag_d = 1'b0;
    end else if (wr_ctrl) begin
      flag_d = 1'b1; // software may set it to force the event
    end
  end

  // limit registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gt_hi_q <= GT_RST;
      gt_lo_q <= GT_RST;
      lt_hi_q <= LT_RST;
      lt_lo_q <= LT_RST;
    end else begin
      if (wr_gt_hi) gt_hi_q <= i_sfr_wdata;
      if (wr_gt_lo) gt_lo_q <= i_sfr_wdata;
      if (wr_lt_hi) lt_hi_q <= i_sfr_wdata;
      if (wr_lt_lo) lt_lo_q <= i_sfr_wdata;
    end
  end

  // selector, control and reference registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= INPUT_SEL_RST;
      ctrl_q <= CONV_CTRL_RST;
      flag_q <= 1'b0;
      ref_q <= REF_CTRL_RST;
    end else begin
      if (wr_sel) sel_q <= i_sfr_wdata[4:0];
      if (wr_ctrl) ctrl_q <= i_sfr_wdata;
      flag_q <= flag_d;
      if (wr_ref) ref_q <= i_sfr_wdata;
    end
  end

  // offset registers: capture the factory value once after reset release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tofs_hi_q <= 8'h00;
      tofs_lo_q <= 2'h0;
      trim_loaded_q <= 1'b0;
    end else if (!trim_loaded_q) begin
      tofs_hi_q <= i_trim_offset[9:2];
      tofs_lo_q <= i_trim_offset[1:0];
      trim_loaded_q <= 1'b1;
    end else begin
      if (wr_tofs_hi) tofs_hi_q <= i_sfr_wdata;
      if (wr_tofs_lo) tofs_lo_q <= i_sfr_wdata[7:6];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_sfr_addr == ADDR_GT_HI) begin
      rdata_d = gt_hi_q;
    end else if (i_sfr_addr == ADDR_GT_LO) begin
      rdata_d = gt_lo_q;
    end else if (i_sfr_addr == ADDR_LT_HI) begin
      rdata_d = lt_hi_q;
    end else if (i_sfr_addr == ADDR_LT_LO) begin
      rdata_d = lt_lo_q;
    end else if (i_sfr_addr == ADDR_INPUT_SEL) begin
      rdata_d = {3'h0, sel_q};
    end else if (i_sfr_addr == ADDR_CONV_CTRL) begin
      rdata_d = ctrl_q;
      rdata_d[WIN_FLAG_BIT] = flag_q;
    end else if (i_sfr_addr == ADDR_REF_CTRL) begin
      rdata_d = ref_q;
    end else if (i_sfr_addr == ADDR_TEMP_OFS_HI) begin
      rdata_d = tofs_hi_q;
    end else if (i_sfr_addr == ADDR_TEMP_OFS_LO) begin
      rdata_d = {tofs_lo_q, 6'h00};
    end
  end

  // read data register, updated only on a read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // one switch per port pin, codes 0 to 15
  generate
    for (genvar i = 0; i < PORT_PINS; i++) begin : g_pin
      assign pin_sel[i] = (sel_q == 5'(i));
    end
  endgenerate

  // outputs
  assign o_sfr_rdata = rdata_q;
  assign o_window_flag = flag_q;
  assign o_port0_sel = pin_sel[7:0];
  assign o_port1_sel = pin_sel[15:8];
  assign o_temp_sel = (sel_q == SEL_TEMP);
  assign o_supply_sel = (sel_q == SEL_SUPPLY);
  assign o_temp_sensor_en = ref_q[TEMP_EN_BIT];
  assign o_conv_ctrl = {ctrl_q[7:WIN_FLAG_BIT+1], flag_q, ctrl_q[WIN_FLAG_BIT-1:0]};

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  flag_set_a: assert property (i_conv_done && win.match |=> o_window_flag)
    else $error("window flag not set after a match");
  flag_sticky_a: assert property (o_window_flag && !flag_clr |=> o_window_flag)
    else $error("window flag dropped without a clear");
  flag_clear_a: assert property (flag_clr && !win_hit |=> !o_window_flag)
    else $error("window flag not cleared by a zero write");
  inside_hit_a: assert property (
    (win.lt_word > win.gt_word) && (win.conv_word > win.gt_word)
    && (win.conv_word < win.lt_word) && i_conv_done |=> o_window_flag)
    else $error("inside window word did not raise the flag");
  outside_hit_a: assert property (
    (win.lt_word <= win.gt_word) && i_conv_done
    && ((win.conv_word < win.gt_word) || (win.conv_word > win.lt_word)) |=> o_window_flag)
    else $error("outside window word did not raise the flag");
  inside_miss_a: assert property (
    (win.lt_word > win.gt_word) && (win.conv_word <= win.gt_word) |-> !win.match)
    else $error("inside mode matched a word at or below gt");
  sel_read_a: assert property (
    wr_sel ##1 (i_sfr_rd && i_sfr_addr == ADDR_INPUT_SEL)
    |=> o_sfr_rdata == {3'h0, $past(i_sfr_wdata[4:0], 2)})
    else $error("selector readback wrong");
  lt_low_rw_a: assert property (
    wr_lt_lo ##1 (i_sfr_rd && i_sfr_addr == ADDR_LT_LO) |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
    else $error("less-than low byte readback wrong");
  mux_none_a: assert property (
    wr_sel && i_sfr_wdata[4:0] > SEL_SUPPLY
    |=> !o_temp_sel && !o_supply_sel && o_port0_sel == 8'h00 && o_port1_sel == 8'h00)
    else $error("reserved selector code drove a switch");
  gt_pair_a: assert property (wr_gt_hi |=> win.gt_word[15:8] == $past(i_sfr_wdata))
    else $error("greater-than high byte not stored");
  temp_en_a: assert property (
    wr_ref |=> o_temp_sensor_en == $past(i_sfr_wdata[TEMP_EN_BIT]))
    else $error("temperature sensor enable not following write");

  inside_c: cover property ((win.lt_word > win.gt_word) && win_hit);
  outside_c: cover property ((win.lt_word <= win.gt_word) && win_hit);
  temp_meas_c: cover property (o_temp_sel && o_temp_sensor_en && i_conv_done);
  clear_c: cover property (o_window_flag && flag_clr ##1 !o_window_flag);
endmodule

// *** core/awis_pkg.sv ***
// package: register map, reset values and field positions for the window and input select block
package awis_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] ADDR_INPUT_SEL = 8'hBB;
  localparam logic [7:0] ADDR_GT_LO = 8'hC3;
  localparam logic [7:0] ADDR_GT_HI = 8'hC4;
  localparam logic [7:0] ADDR_LT_LO = 8'hC5;
  localparam logic [7:0] ADDR_LT_HI = 8'hC6;
  localparam logic [7:0] ADDR_TEMP_OFS_LO = 8'h85;
  localparam logic [7:0] ADDR_TEMP_OFS_HI = 8'h86;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_REF_CTRL = 8'hD1;
  // field positions
  localparam int WIN_FLAG_BIT = 3;
  localparam int TEMP_EN_BIT = 2;
  localparam int CONV_BITS = 10;
  localparam int PORT_PINS = 16;
  // reset values
  localparam logic [7:0] GT_RST = 8'hFF;
  localparam logic [7:0] LT_RST = 8'h00;
  localparam logic [4:0] INPUT_SEL_RST = 5'h1F;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  // selector codes for the internal sources
  localparam logic [4:0] SEL_TEMP = 5'h10;
  localparam logic [4:0] SEL_SUPPLY = 5'h11;
endpackage

// *** core/awis_win_if.sv ***
// interface: limits and conversion word passed to the window comparator
interface awis_win_if;
  logic [15:0] gt_word; // greater-than limit pair
  logic [15:0] lt_word; // less-than limit pair
  logic [15:0] conv_word; // zero-extended conversion result
  logic match; // window condition met for conv_word
  modport cmp (input gt_word, input lt_word, input conv_word, output match);
  modport ctl (output gt_word, output lt_word, output conv_word, input match);
endinterface

// *** core/awis_window_cmp.sv ***
// window comparator: inside or outside test of an unsigned word against two limits
module awis_window_cmp (
  awis_win_if.cmp win
);
  import awis_pkg::*;
  // inside mode is chosen by the limits themselves
  wire inside_mode = win.lt_word > win.gt_word;
  // unsigned compares, strict on both sides
  wire above_gt = win.conv_word > win.gt_word;
  wire below_lt = win.conv_word < win.lt_word;
  wire below_gt = win.conv_word < win.gt_word;
  wire above_lt = win.conv_word > win.lt_word;
  // inside: strictly between the limits
  wire inside_hit = above_gt && below_lt;
  // outside: strictly below gt or strictly above lt
  wire outside_hit = below_gt || above_lt;
  assign win.match = inside_mode ? inside_hit : outside_hit;
endmodule

// *** verif/tb.sv ***
// testbench: register port, window flag, input selector and sensor control
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import awis_pkg::*;
  logic clk, rst_n, wr, rd, done; // clock, reset and strobes
  logic [7:0] addr, wdata, rdata, p0, p1, cctrl, d;
  logic [9:0] word, trim; // conversion word and factory offset
  logic flag, temp_sel, supply_sel, temp_en;
  logic [15:0] glim, llim; // limits as last written
  logic exp_flag; // expected sticky flag
  logic [9:0] cw [4] = '{10'h040, 10'h041, 10'h07F, 10'h080}; // boundary words
  // registers that take random bytes and read them back unchanged
  logic [7:0] ra [6] = '{ADDR_GT_HI, ADDR_GT_LO, ADDR_LT_HI, ADDR_LT_LO, ADDR_TEMP_OFS_HI,
    ADDR_CONV_CTRL};
  int n_mismatch, checks_done;
  awis_top u_awis_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .i_conv_word(word), .i_conv_done(done), .i_trim_offset(trim), .o_window_flag(flag),
    .o_port0_sel(p0), .o_port1_sel(p1), .o_temp_sel(temp_sel), .o_supply_sel(supply_sel),
    .o_temp_sensor_en(temp_en), .o_conv_ctrl(cctrl));
  // free-running core clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one register write, strobe held for one edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one register read, data taken once it has settled
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("sfr_rdata", {8'h00, rdata}, {8'h00, v});
  endtask
  // write then read the same register on back-to-back edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("sfr_wr_rd", {8'h00, rdata}, {8'h00, r});
  endtask
  // expected window result for a zero-extended word
  function automatic logic win_hit(input logic [15:0] g, input logic [15:0] l, input logic [9:0] w);
    if (l > g) begin
      return ({6'h00, w} > g) && ({6'h00, w} < l); // inside mode
    end
    return ({6'h00, w} < g) || ({6'h00, w} > l); // outside mode
  endfunction
  // one conversion pulse, then flag and its control bit checked
  task automatic conv(input logic [9:0] w);
    @(posedge clk);
    word <= w;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
    exp_flag = exp_flag | win_hit(glim, llim, w);
    chk("window_flag", {14'h0, cctrl[WIN_FLAG_BIT], flag}, {14'h0, exp_flag, exp_flag});
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #(40 * 20000);
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {wr, rd, done, exp_flag} = 4'h0;
    {addr, wdata, word} = 26'h0;
    trim = 10'h2D6;
    void'($urandom(5171));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values and offset load
    rd_chk(ADDR_INPUT_SEL, 8'h1F);
    rd_chk(ADDR_LT_LO, 8'h00);
    rd_chk(ADDR_LT_HI, 8'h00);
    rd_chk(ADDR_GT_HI, 8'hFF);
    rd_chk(ADDR_GT_LO, 8'hFF);
    rd_chk(ADDR_TEMP_OFS_HI, trim[9:2]);
    rd_chk(ADDR_TEMP_OFS_LO, {trim[1:0], 6'h00});
    rd_chk(8'h00, 8'h00);
    chk("idle_outputs", {p1, p0}, 16'h0000);
    chk("idle_flag", {14'h0, flag, temp_en}, 16'h0000);
    $display("test reset done");
    // every selector code, random junk in the read-only bits
    for (int c = 0; c < 32; c++) begin
      reg_wr(ADDR_INPUT_SEL, {3'($urandom), 5'(c)});
      #1;
      chk("port_sel", {p1, p0}, (c < 16) ? 16'(1 << c) : 16'h0000);
      chk("int_sel", {14'h0, temp_sel, supply_sel}, {14'h0, c == 16, c == 17});
      rd_chk(ADDR_INPUT_SEL, {3'h0, 5'(c)});
    end
    $display("test selector done");
    // limit byte and other register read-back
    reg_wr(ADDR_LT_LO, 8'h80);
    rd_chk(ADDR_LT_LO, 8'h80);
    wr_rd(ADDR_LT_LO, 8'h80, 8'h80);
    wr_rd(ADDR_INPUT_SEL, 8'hE9, 8'h09);
    wr_rd(ADDR_TEMP_OFS_LO, 8'hFF, 8'hC0);
    for (int k = 0; k < 6; k++) begin
      d = 8'($urandom);
      wr_rd(ra[k], d, d);
    end
    chk("conv_ctrl", {8'h00, cctrl}, {8'h00, d});
    $display("test limits done");
    // window: boundary words in both modes, then random limits
    for (int t = 0; t < 40; t++) begin
      glim = (t < 4) ? 16'h0040 : (t < 8) ? 16'h0080 : 16'($urandom_range(0, 1023));
      llim = (t < 4) ? 16'h0080 : (t < 8) ? 16'h0040 : 16'($urandom_range(0, 1023));
      if (t == 8) begin
        llim = 16'hFFFF;
      end
      reg_wr(ADDR_GT_HI, glim[15:8]);
      reg_wr(ADDR_GT_LO, glim[7:0]);
      reg_wr(ADDR_LT_HI, llim[15:8]);
      reg_wr(ADDR_LT_LO, llim[7:0]);
      reg_wr(ADDR_CONV_CTRL, 8'h00);
      exp_flag = 1'b0;
      conv((t < 8) ? cw[t % 4] : (t == 8) ? 10'h3FF : 10'($urandom));
      conv(10'($urandom));
    end
    $display("test window done");
    // sensor enable bit in reference control
    reg_wr(ADDR_REF_CTRL, 8'h04);
    #1;
    chk("temp_en", {15'h0, temp_en}, 16'h0001);
    reg_wr(ADDR_REF_CTRL, 8'hFB);
    #1;
    chk("temp_en", {15'h0, temp_en}, 16'h0000);
    rd_chk(ADDR_REF_CTRL, 8'hFB);
    $display("test sensor done");
    stop_test();
  end
endmodule
